// >>> hw/rsp_pkg.sv
package rsp_pkg;
   // ***************************
   // serial framing
   // ***************************
   localparam int            BURST_BITS    = 8;
   localparam int            WORD_BITS     = 16;
   localparam int            ADDR_BITS     = 6;
   localparam int            HDR_DIR_BIT   = 7;
   localparam int            MIN_EDGES     = 24;
   localparam int            BUF_WORDS     = 64;
   localparam logic [3:0]    HDR_LAST_BIT  = 4'h7;
   localparam logic [3:0]    WORD_LAST_BIT = 4'hf;
   // ***************************
   // device locations
   // ***************************
   localparam logic [5:0]    ADDR_SOFT_RESET = 6'h00;
   localparam logic [5:0]    ADDR_RX_BUF     = 6'h01;
   localparam logic [5:0]    ADDR_TX_BUF     = 6'h02;
   localparam logic [5:0]    ADDR_WRAP       = 6'h03;
   localparam logic [5:0]    ADDR_LAST       = 6'h3f;
   localparam logic [5:0]    ADDR_CTRL_B     = 6'h07;
   localparam logic [5:0]    ADDR_GPIO_OUT   = 6'h0c;
   localparam int            FLOAT_IDLE_BIT  = 11;
   localparam int            STREAM_MODE_BIT = 2;
   localparam int            DRIVE_LSB       = 9;
   localparam logic [15:0]   CTRL_B_RESET    = 16'h0800;
   localparam logic [15:0]   GPIO_OUT_RESET  = 16'h0000;
   localparam logic [63:0]   IMPL_MASK_DEF   = 64'hffff_ffff_ffff_fff8;
   // ***************************
   // host register map (apb)
   // ***************************
   localparam logic [11:0]   HOST_CTRL_OFS   = 12'h000;
   localparam logic [11:0]   HOST_WDATA_OFS  = 12'h004;
   localparam logic [11:0]   HOST_RDATA_OFS  = 12'h008;
   localparam logic [11:0]   HOST_STATUS_OFS = 12'h00c;
   localparam int            CTRL_DIR_BIT    = 7;
   localparam int            CTRL_GO_BIT     = 8;
   localparam int            CTRL_LAST_BIT   = 9;
   // ***************************
   // timing
   // ***************************
   localparam int            CLK_PERIOD_NS   = 100;
   localparam int            LINK_HALF_NS    = 1600;
   localparam int            LINK_HALF_CYC   = LINK_HALF_NS / CLK_PERIOD_NS;
endpackage

// >>> hw/rsp_if.sv
`timescale 1ns/10ps
`default_nettype none
interface rsp_if;
   logic       sclk;
   logic       csN;
   logic       mosi;
   logic       misoO;
   logic       misoOe;
   logic [1:0] misoDrive;
   wire        miso;

   // a released wire shows the opposite of the last bit, so a host that
   // samples it outside its own frame reads garbage, not a stale bit
   assign miso = misoOe ? misoO : ~misoO;

   modport device (input sclk, input csN, input mosi,
                   output misoO, output misoOe, output misoDrive);
   modport host   (output sclk, output csN, output mosi, input miso);
endinterface
`default_nettype wire

// >>> hw/rsp_sync.sv
`timescale 1ns/10ps
`default_nettype none
module rsp_sync #(
   parameter int W = 1
) (
   input  wire logic         clk,
   input  wire logic         arst_n,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] f;
   } rsp_sync_t;

   rsp_sync_t r_q;
   rsp_sync_t r_d;

   // a bit changes only once the second and third stages agree
   always_comb begin
      r_d    = r_q;
      r_d.s1 = d;
      r_d.s2 = r_q.s1;
      r_d.s3 = r_q.s2;
      for (int i = 0; i < W; i++) begin
         if (r_q.s2[i] == r_q.s3[i]) begin
            r_d.f[i] = r_q.s3[i];
         end
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         r_q <= '0;
      end else begin
         r_q <= r_d;
      end
   end

   assign q = r_q.f;
endmodule
`default_nettype wire

// >>> hw/rsp_device.sv
`timescale 1ns/10ps
`default_nettype none
// Overview of operation
// - frame held low, three bursts minimum
// - sample rising edge, change miso falling
// - two-bit miso drive level, default 00
// - float bit set: miso floats when idle
// - float bit clear: miso low when idle
// - eight bits per burst, msb first
// - first burst is header from host
// - address from low six header bits
// - direction bit one reads, zero writes
// - never both directions at once
// - singular access carries one 16-bit word
// - frame select rising ends transaction
// - under 24 edges changes no register
// - payload whole words only
// - word shifted bit 15 first
// - four rx symbols packed per word
// - packet mode buffers, stream mode direct
// - tx words unpacked in reverse order
// - held frame continues at next locations
// - pointer increments except at 01 and 02, 63 wraps to 03
// - rx buffer address advances buffer pointer
// - write to location 00 soft-resets
module rsp_device import rsp_pkg::*; #(
   parameter logic [63:0] IMPL_MASK = IMPL_MASK_DEF
) (
   input  wire logic   clk,
   input  wire logic   arst_n,
   rsp_if.device       link,
   input  wire logic   [3:0] rxSymbol,
   input  wire logic   rxSymbolValid,
   input  wire logic   rxFrameStart,
   input  wire logic   txStart,
   input  wire logic   txSymbolReq,
   output logic        [3:0] txSymbol,
   output logic        softReset
);
   typedef struct packed {
      logic [63:0][15:0]          regs;
      logic [BUF_WORDS-1:0][15:0] rxBuf;
      logic [BUF_WORDS-1:0][15:0] txBuf;
      logic                       sclkPrev;
      logic                       hdrDone;
      logic                       dirRead;
      logic [5:0]                 addr;
      logic [3:0]                 bitCnt;
      logic [15:0]                inSh;
      logic [15:0]                outSh;
      logic                       misoBit;
      logic                       misoO;
      logic                       misoOe;
      logic [5:0]                 rxWr;
      logic [5:0]                 rxRd;
      logic [5:0]                 txWr;
      logic [15:0]                packWord;
      logic [1:0]                 packCnt;
      logic [15:0]                streamWord;
      logic [7:0]                 txPtr;
      logic [3:0]                 txSym;
      logic                       softRst;
   } rsp_dev_t;

   rsp_dev_t   r_q;
   rsp_dev_t   r_d;
   logic [2:0] pins;
   logic       sclkS;
   logic       csNS;
   logic       mosiS;

   // ***************************
   // pin synchronisers
   // ***************************
   rsp_sync #(.W(3)) u_sync (
      .clk    (clk),
      .arst_n (arst_n),
      // select travels inverted so the cleared sync reads as idle after reset
      .d      ({link.sclk, ~link.csN, link.mosi}),
      .q      (pins)
   );
   assign sclkS = pins[2];
   assign csNS  = ~pins[1];
   assign mosiS = pins[0];

   // ***************************
   // serial engine
   // ***************************
   always_comb begin
      logic        rise;
      logic        fall;
      logic        floatIdle;
      logic        stream;
      logic [15:0] word;
      logic [5:0]  nxt;
      logic [5:0]  a;
      rise      = 1'b0;
      fall      = 1'b0;
      floatIdle = 1'b0;
      stream    = 1'b0;
      word      = '0;
      nxt       = '0;
      a         = '0;
      r_d           = r_q;
      r_d.softRst   = 1'b0;
      r_d.sclkPrev  = sclkS;
      rise      = sclkS & ~r_q.sclkPrev;
      fall      = ~sclkS & r_q.sclkPrev;
      floatIdle = r_q.regs[ADDR_CTRL_B][FLOAT_IDLE_BIT];
      stream    = r_q.regs[ADDR_CTRL_B][STREAM_MODE_BIT];

      if (csNS) begin
         // idle: partial words are dropped here, nothing was committed
         r_d.hdrDone = 1'b0;
         r_d.bitCnt  = '0;
         r_d.dirRead = 1'b0;
         r_d.misoBit = 1'b0;
         r_d.rxRd    = '0;
         r_d.txWr    = '0;
      end else if (rise) begin
         r_d.inSh = {r_q.inSh[14:0], mosiS};
         r_d.bitCnt = r_q.bitCnt + 4'h1;
         if (!r_q.hdrDone) begin
            if (r_q.bitCnt == HDR_LAST_BIT) begin
               r_d.hdrDone = 1'b1;
               r_d.bitCnt  = '0;
               r_d.dirRead = r_d.inSh[HDR_DIR_BIT];
               r_d.addr    = r_d.inSh[ADDR_BITS-1:0];
               a           = r_d.addr;
               if (r_d.dirRead) begin
                  if (a == ADDR_RX_BUF) begin
                     r_d.outSh = stream ? r_q.streamWord : r_q.rxBuf[r_q.rxRd];
                     r_d.rxRd  = r_q.rxRd + 6'h01;
                  end else begin
                     r_d.outSh = IMPL_MASK[a] ? r_q.regs[a] : 16'h0000;
                  end
               end
            end
         end else if (r_q.bitCnt == WORD_LAST_BIT) begin
            r_d.bitCnt = '0;
            a    = r_q.addr;
            word = r_d.inSh;
            if (!r_q.dirRead) begin
               // commit only once the whole word is in
               if (a == ADDR_SOFT_RESET) begin
                  r_d.softRst = 1'b1;
                  r_d.regs    = '0;
                  r_d.regs[ADDR_CTRL_B]   = CTRL_B_RESET;
                  r_d.regs[ADDR_GPIO_OUT] = GPIO_OUT_RESET;
                  r_d.rxWr    = '0;
                  r_d.packCnt = '0;
                  r_d.txPtr   = '0;
               end else if (a == ADDR_TX_BUF) begin
                  r_d.txBuf[r_q.txWr] = word;
                  r_d.txWr = r_q.txWr + 6'h01;
               end else if (IMPL_MASK[a]) begin
                  r_d.regs[a] = word;
               end
            end
            if (a == ADDR_RX_BUF || a == ADDR_TX_BUF) begin
               nxt = a;
            end else if (a == ADDR_LAST) begin
               nxt = ADDR_WRAP;
            end else begin
               nxt = a + 6'h01;
            end
            r_d.addr = nxt;
            if (r_q.dirRead) begin
               if (nxt == ADDR_RX_BUF) begin
                  r_d.outSh = stream ? r_q.streamWord : r_q.rxBuf[r_q.rxRd];
                  r_d.rxRd  = r_q.rxRd + 6'h01;
               end else begin
                  r_d.outSh = IMPL_MASK[nxt] ? r_q.regs[nxt] : 16'h0000;
               end
            end
         end
      end else if (fall) begin
         if (r_q.hdrDone && r_q.dirRead) begin
            r_d.misoBit = r_q.outSh[15];
            r_d.outSh   = {r_q.outSh[14:0], 1'b0};
         end else begin
            r_d.misoBit = 1'b0;
         end
      end

      // ***************************
      // miso drive
      // ***************************
      if (csNS) begin
         r_d.misoOe = ~floatIdle;
         r_d.misoO  = 1'b0;
      end else begin
         r_d.misoOe = 1'b1;
         r_d.misoO  = r_d.misoBit;
      end

      // ***************************
      // radio symbol side
      // ***************************
      if (rxFrameStart) begin
         r_d.packCnt = '0;
         r_d.rxWr    = '0;
      end else if (rxSymbolValid) begin
         // first symbol lands low, so msb-first reads show them reversed
         r_d.packWord[{r_q.packCnt, 2'b00} +: 4] = rxSymbol;
         r_d.packCnt = r_q.packCnt + 2'h1;
         if (r_q.packCnt == 2'h3) begin
            if (stream) begin
               r_d.streamWord = r_d.packWord;
            end else begin
               r_d.rxBuf[r_q.rxWr] = r_d.packWord;
               r_d.rxWr = r_q.rxWr + 6'h01;
            end
         end
      end
      if (txStart) begin
         r_d.txPtr = '0;
      end else if (txSymbolReq) begin
         r_d.txSym = r_q.txBuf[r_q.txPtr[7:2]][{r_q.txPtr[1:0], 2'b00} +: 4];
         r_d.txPtr = r_q.txPtr + 8'h01;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         r_q <= '0;
         r_q.regs[ADDR_CTRL_B]   <= CTRL_B_RESET;
         r_q.regs[ADDR_GPIO_OUT] <= GPIO_OUT_RESET;
         r_q.misoOe              <= 1'b0;
      end else begin
         r_q <= r_d;
      end
   end

   assign link.misoO     = r_q.misoO;
   assign link.misoOe    = r_q.misoOe;
   assign link.misoDrive = r_q.regs[ADDR_GPIO_OUT][DRIVE_LSB +: 2];
   assign txSymbol       = r_q.txSym;
   assign softReset      = r_q.softRst;
endmodule
`default_nettype wire

// >>> hw/rsp_host.sv
`timescale 1ns/10ps
`default_nettype none
module rsp_host import rsp_pkg::*; #(
   parameter int HALF_CYC = LINK_HALF_CYC
) (
   input  wire logic        clk,
   input  wire logic        arst_n,
   rsp_if.host              link,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr
);
   typedef enum logic [4:0] {
      ST_IDLE = 5'b00001,
      ST_LOW  = 5'b00010,
      ST_HIGH = 5'b00100,
      ST_TAIL = 5'b01000,
      ST_GAP  = 5'b10000
   } rsp_host_st_t;

   typedef struct packed {
      rsp_host_st_t st;
      logic [7:0]   cnt;
      logic [4:0]   bitsLeft;
      logic [23:0]  txSh;
      logic [15:0]  rxSh;
      logic [15:0]  rdata;
      logic [15:0]  wdata;
      logic         last;
      logic         open;
      logic         csN;
      logic         sclk;
      logic         mosi;
      logic [31:0]  prdata;
      logic         err;
   } rsp_host_t;

   localparam logic [7:0] HALF = 8'(HALF_CYC);

   rsp_host_t r_q;
   rsp_host_t r_d;
   logic      misoS;

   rsp_sync #(.W(1)) u_sync (
      .clk    (clk),
      .arst_n (arst_n),
      .d      (link.miso),
      .q      (misoS)
   );

   always_comb begin
      logic wr;
      logic go;
      logic hit;
      wr  = psel & penable & pwrite;
      go  = 1'b0;
      hit = 1'b0;
      r_d = r_q;
      // ***************************
      // apb slave
      // ***************************
      if (psel && !penable) begin
         hit = (paddr == HOST_CTRL_OFS) || (paddr == HOST_WDATA_OFS) ||
               (paddr == HOST_RDATA_OFS) || (paddr == HOST_STATUS_OFS);
         r_d.err    = ~hit;
         r_d.prdata = '0;
         if (!pwrite) begin
            unique case (paddr)
               HOST_WDATA_OFS:  r_d.prdata = {16'h0000, r_q.wdata};
               HOST_RDATA_OFS:  r_d.prdata = {16'h0000, r_q.rdata};
               HOST_STATUS_OFS: r_d.prdata = {30'h0, r_q.open, r_q.st != ST_IDLE};
               default:         r_d.prdata = '0;
            endcase
         end
      end
      if (wr && paddr == HOST_WDATA_OFS) begin
         r_d.wdata = pwdata[15:0];
      end
      go = wr && paddr == HOST_CTRL_OFS && pwdata[CTRL_GO_BIT] && r_q.st == ST_IDLE;

      // ***************************
      // link sequencer
      // ***************************
      unique case (r_q.st)
         ST_IDLE: begin
            if (go) begin
               r_d.last = pwdata[CTRL_LAST_BIT];
               if (!r_q.open) begin
                  // read payload goes out as zeros: one direction only
                  r_d.txSh = {pwdata[CTRL_DIR_BIT], 1'b0, pwdata[5:0],
                              pwdata[CTRL_DIR_BIT] ? 16'h0000 : r_q.wdata};
                  r_d.bitsLeft = 5'd24;
               end else begin
                  r_d.txSh = {r_q.wdata, 8'h00};
                  r_d.bitsLeft = 5'd16;
               end
               r_d.csN  = 1'b0;
               r_d.open = 1'b1;
               r_d.mosi = r_d.txSh[23];
               r_d.cnt  = HALF;
               r_d.st   = ST_LOW;
            end
         end
         ST_LOW: begin
            r_d.cnt = r_q.cnt - 8'h01;
            if (r_q.cnt == 8'h01) begin
               r_d.sclk = 1'b1;
               r_d.rxSh = {r_q.rxSh[14:0], misoS};
               r_d.cnt  = HALF;
               r_d.st   = ST_HIGH;
            end
         end
         ST_HIGH: begin
            r_d.cnt = r_q.cnt - 8'h01;
            if (r_q.cnt == 8'h01) begin
               r_d.sclk     = 1'b0;
               r_d.txSh     = {r_q.txSh[22:0], 1'b0};
               r_d.mosi     = r_d.txSh[23];
               r_d.bitsLeft = r_q.bitsLeft - 5'd1;
               r_d.cnt      = HALF;
               if (r_q.bitsLeft == 5'd1) begin
                  r_d.rdata = r_q.rxSh;
                  r_d.mosi  = 1'b0;
                  r_d.st    = ST_TAIL;
               end else begin
                  r_d.st = ST_LOW;
               end
            end
         end
         ST_TAIL: begin
            r_d.cnt = r_q.cnt - 8'h01;
            if (r_q.cnt == 8'h01) begin
               r_d.cnt = HALF;
               if (r_q.last) begin
                  r_d.csN = 1'b1;
                  r_d.st  = ST_GAP;
               end else begin
                  r_d.st = ST_IDLE;
               end
            end
         end
         ST_GAP: begin
            r_d.cnt = r_q.cnt - 8'h01;
            if (r_q.cnt == 8'h01) begin
               r_d.open = 1'b0;
               r_d.st   = ST_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         r_q     <= '0;
         r_q.st  <= ST_IDLE;
         r_q.csN <= 1'b1;
      end else begin
         r_q <= r_d;
      end
   end

   assign link.sclk = r_q.sclk;
   assign link.csN  = r_q.csN;
   assign link.mosi = r_q.mosi;
   assign prdata    = r_q.prdata;
   assign pready    = psel & penable;
   assign pslverr   = psel & penable & r_q.err;
endmodule
`default_nettype wire

// >>> test/rsp_link_asserts.sv
`timescale 1ns/10ps
`default_nettype none
// ***************
// link checker
// ***************
module rsp_link_asserts (
   input  wire logic       clk,
   input  wire logic       arst_n,
   input  wire logic       sclk,
   input  wire logic       csN,
   input  wire logic       mosi,
   input  wire logic       misoO,
   input  wire logic       misoOe,
   input  wire logic [1:0] misoDrive
);
   logic [7:0] edgeCnt_q;
   logic       dir_q;
   // rising link edges seen in the open frame; the value survives the
   // edge at which csN is first seen high, so the end check sees the total
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         edgeCnt_q <= 8'h00;
         dir_q     <= 1'b0;
      end else if (csN) begin
         edgeCnt_q <= 8'h00;
      end else if ($rose(sclk)) begin
         edgeCnt_q <= edgeCnt_q + 8'h01;
         if (edgeCnt_q == 8'h00)
            dir_q <= mosi;
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);
   AST_SCLK_IDLE_LOW: assert property (csN |-> !sclk)
      else $error("link clock high outside frame");
   AST_MOSI_STABLE_HIGH: assert property (sclk |-> $stable(mosi))
      else $error("mosi moved while link clock high");
   AST_MISO_ON_LOW: assert property (!csN && $changed(misoO) |-> !sclk)
      else $error("miso moved while link clock high");
   AST_FRAME_START: assert property ($fell(csN) |-> !sclk && edgeCnt_q == 8'h00)
      else $error("frame opened badly");
   AST_FRAME_LENGTH: assert property ($rose(csN) |->
      edgeCnt_q >= 8'h18 && edgeCnt_q[3:0] == 4'h8)
      else $error("frame not header plus whole words");
   AST_HDR_BIT6: assert property ($rose(sclk) && edgeCnt_q == 8'h01 |-> !mosi)
      else $error("header bit six not zero");
   AST_WRITE_MISO_LOW: assert property (!csN && !dir_q && edgeCnt_q != 8'h00
      |-> !misoO)
      else $error("miso active during write");
   AST_OE_IN_FRAME: assert property (!csN && edgeCnt_q != 8'h00 |-> misoOe)
      else $error("miso not driven in frame");
   AST_IDLE_LEVEL: assert property (csN [*8] |-> !misoOe || !misoO)
      else $error("idle miso driven high");
   AST_DRIVE_RESET: assert property ($rose(arst_n) |-> misoDrive == 2'b00)
      else $error("drive level not weakest after reset");
endmodule
`default_nettype wire

// >>> test/testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
   import rsp_pkg::*;
   logic        clk, arst_n, psel, penable, pwrite, pready, pslverr, e;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, q, r;
   logic [3:0]  rxSymbol, txSymbol;
   logic        rxSymbolValid, rxFrameStart, txStart, txSymbolReq, softReset;
   int          n_fail, checked, nSoft;
   logic [15:0] vals [3] = '{16'h1111, 16'h2222, 16'h3333};
   rsp_if i_rsp_if ();
   rsp_if i_rsp_if_b ();
   // location 05 left out so unimplemented behaviour is reachable
   rsp_device #(.IMPL_MASK(64'hffff_ffff_ffff_ffd8)) i_rsp_device (
      .clk(clk), .arst_n(arst_n), .link(i_rsp_if), .rxSymbol(rxSymbol),
      .rxSymbolValid(rxSymbolValid), .rxFrameStart(rxFrameStart),
      .txStart(txStart), .txSymbolReq(txSymbolReq), .txSymbol(txSymbol),
      .softReset(softReset));
   // second device faces a bench driver that breaks framing on purpose
   rsp_device i_rsp_device_b (
      .clk(clk), .arst_n(arst_n), .link(i_rsp_if_b), .rxSymbol(rxSymbol),
      .rxSymbolValid(1'b0), .rxFrameStart(rxFrameStart), .txStart(txStart),
      .txSymbolReq(1'b0), .txSymbol(), .softReset());
   rsp_host i_rsp_host (
      .clk(clk), .arst_n(arst_n), .link(i_rsp_if), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr));
   rsp_link_asserts i_rsp_link_asserts (
      .clk(clk), .arst_n(arst_n), .sclk(i_rsp_if.sclk), .csN(i_rsp_if.csN),
      .mosi(i_rsp_if.mosi), .misoO(i_rsp_if.misoO),
      .misoOe(i_rsp_if.misoOe), .misoDrive(i_rsp_if.misoDrive));
   // ***************
   // tasks
   // ***************
   task conclude;
      if (n_fail == 0 && checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         n_fail++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
            output logic [31:0] rd, output logic err);
      int n;
      @(posedge clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      if (n >= 20)
         n_fail++;
   endtask
   // one link word; a word with last set also lets the frame close
   task xfer(input logic [5:0] a, input logic rd, input logic last,
             input logic [15:0] wd, output logic [31:0] res);
      int n;
      apb(1'b1, HOST_WDATA_OFS, {16'h0000, wd}, r, e);
      apb(1'b1, HOST_CTRL_OFS, {22'h0, last, 1'b1, rd, 1'b0, a}, r, e);
      n = 0;
      r = 32'h1;
      while (r[0] !== 1'b0 && n < 1000) begin
         apb(1'b0, HOST_STATUS_OFS, 32'h0, r, e);
         n++;
      end
      if (n >= 1000)
         n_fail++;
      apb(1'b0, HOST_RDATA_OFS, 32'h0, r, e);
      res = {16'h0000, r[15:0]};
      if (last)
         repeat (40) @(posedge clk);
   endtask
   // bit-banged writer at an 800 ns link period
   task bb(input int n, input logic [23:0] v);
      @(posedge clk);
      i_rsp_if_b.csN <= 1'b0;
      for (int i = 0; i < n; i++) begin
         i_rsp_if_b.mosi <= v[23-i];
         repeat (4) @(posedge clk);
         i_rsp_if_b.sclk <= 1'b1;
         repeat (4) @(posedge clk);
         i_rsp_if_b.sclk <= 1'b0;
      end
      repeat (4) @(posedge clk);
      i_rsp_if_b.csN  <= 1'b1;
      i_rsp_if_b.mosi <= ~i_rsp_if_b.mosi;
      repeat (12) @(posedge clk);
   endtask
   // m picks {rxFrameStart, rxSymbolValid, txStart, txSymbolReq}
   task pulse(input logic [3:0] m);
      @(posedge clk);
      {rxFrameStart, rxSymbolValid, txStart, txSymbolReq} <= m;
      @(posedge clk);
      {rxFrameStart, rxSymbolValid, txStart, txSymbolReq} <= 4'h0;
   endtask
   // ***************
   // sequence
   // ***************
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   always @(posedge clk)
      if (softReset === 1'b1)
         nSoft++;
   initial begin
      repeat (80000) @(posedge clk);
      n_fail++;
      conclude;
   end
   initial begin
      {arst_n, psel, penable, pwrite, paddr, pwdata} = '0;
      {rxSymbol, rxSymbolValid, rxFrameStart, txStart, txSymbolReq} = '0;
      {n_fail, checked, nSoft} = '0;
      i_rsp_if_b.csN = 1'b1;
      i_rsp_if_b.sclk = 1'b0;
      i_rsp_if_b.mosi = 1'b0;
      repeat (2) @(posedge clk);
      arst_n <= 1'b1;
      repeat (8) @(negedge clk);
      chk({30'h0, i_rsp_if.misoDrive}, 32'h0);
      chk({31'h0, i_rsp_if.misoOe}, 32'h0);
      apb(1'b0, 12'h010, 32'h0, r, e);
      chk({r[30:0], e}, 32'h1);
      xfer(ADDR_CTRL_B, 1'b1, 1'b1, 16'h0, q);
      chk(q, {16'h0, CTRL_B_RESET});
      xfer(ADDR_GPIO_OUT, 1'b0, 1'b1, 16'h0600, q);
      chk({30'h0, i_rsp_if.misoDrive}, 32'h3);
      xfer(ADDR_GPIO_OUT, 1'b1, 1'b1, 16'h0, q);
      chk(q, 32'h0600);
      xfer(ADDR_CTRL_B, 1'b0, 1'b1, 16'h0004, q);
      @(negedge clk);
      chk({31'h0, i_rsp_if.miso}, 32'h0);
      pulse(4'h8);
      for (int k = 0; k < 4; k++) begin
         rxSymbol <= 4'(k + 1);
         pulse(4'h4);
      end
      xfer(ADDR_RX_BUF, 1'b1, 1'b1, 16'h0, q);
      chk(q, 32'h4321);
      for (int k = 0; k < 3; k++)
         xfer(6'h3e, 1'b0, k == 2, vals[k], q);
      for (int k = 0; k < 3; k++) begin
         xfer(6'h3e, 1'b1, k == 2, 16'h0, q);
         chk(q, {16'h0, vals[k]});
      end
      xfer(6'h05, 1'b0, 1'b1, 16'habcd, q);
      xfer(6'h05, 1'b1, 1'b1, 16'h0, q);
      chk(q, 32'h0);
      xfer(ADDR_TX_BUF, 1'b0, 1'b1, 16'h8765, q);
      pulse(4'h2);
      for (int k = 0; k < 4; k++) begin
         pulse(4'h1);
         @(negedge clk);
         chk({28'h0, txSymbol}, 32'(k + 5));
      end
      xfer(ADDR_SOFT_RESET, 1'b0, 1'b1, 16'h0, q);
      chk(nSoft, 32'h1);
      xfer(ADDR_GPIO_OUT, 1'b1, 1'b1, 16'h0, q);
      chk(q, {16'h0, GPIO_OUT_RESET});
      @(negedge clk);
      chk({31'h0, i_rsp_if.misoOe}, 32'h0);
      bb(16, 24'h0c0600);
      chk({30'h0, i_rsp_if_b.misoDrive}, 32'h0);
      bb(24, 24'h0c0600);
      chk({30'h0, i_rsp_if_b.misoDrive}, 32'h3);
      conclude;
   end
endmodule
`default_nettype wire
